// ### aece_core.sv
// iterative aes-128 round core, one round per clock, forward and inverse key schedule
// assumes start only while idle; abort also wipes state and round key
`timescale 1ns/1ps
`include "aece_regs.svh"
module aece_core
  import aece_pkg::*;
(
  // clock and reset
  input wire logic  core_clk_i,
  input wire logic  sys_rst_i,
  // access logic side
  aece_core_if.core cif
);
  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      p = b[i] ? (p ^ x) : p;
      x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1b : 8'h00);
    end
    return p;
  endfunction : gmul
  // field inverse as a to the 254th power; zero maps to zero
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] x3;
    logic [7:0] x12;
    logic [7:0] x;
    x3 = gmul(gmul(a, a), a);
    x12 = gmul(gmul(x3, x3), gmul(x3, x3));
    x = gmul(x12, x3);
    for (int i = 0; i < 4; i++) begin
      x = gmul(x, x);
    end
    return gmul(gmul(x, x12), gmul(a, a));
  endfunction : ginv
  function automatic logic [7:0] rotl(input logic [7:0] b, input int n);
    return 8'((b << n) | (b >> (8 - n)));
  endfunction : rotl
  // computed s-boxes trade area for not carrying two 256-entry tables
  function automatic logic [7:0] sbox(input logic [7:0] a, input logic inv);
    logic [7:0] b;
    b = ginv(a);
    if (inv) begin
      return ginv(rotl(a, 1) ^ rotl(a, 3) ^ rotl(a, 6) ^ 8'h05);
    end
    return b ^ rotl(b, 1) ^ rotl(b, 2) ^ rotl(b, 3) ^ rotl(b, 4) ^ 8'h63;
  endfunction : sbox
  function automatic logic [127:0] sub_bytes(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    o = s;
    for (int i = 0; i < 16; i++) begin
      o[127-8*i -: 8] = sbox(s[127-8*i -: 8], inv);
    end
    return o;
  endfunction : sub_bytes
  function automatic logic [127:0] shift_rows(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    o = s;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        o[127-8*(r+4*c) -: 8] = s[127-8*(r+4*((inv ? c-r+4 : c+r) % 4)) -: 8];
      end
    end
    return o;
  endfunction : shift_rows
  function automatic logic [127:0] mix_cols(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    logic [7:0]   cf [4];
    logic [7:0]   v;
    if (inv) begin
      cf = '{8'h0e, 8'h0b, 8'h0d, 8'h09};
    end else begin
      cf = '{8'h02, 8'h03, 8'h01, 8'h01};
    end
    o = s;
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 4; j++) begin
        v = 8'h00;
        for (int k = 0; k < 4; k++) begin
          v = v ^ gmul(s[127-8*(4*c+k) -: 8], cf[(k-j+4)%4]);
        end
        o[127-8*(4*c+j) -: 8] = v;
      end
    end
    return o;
  endfunction : mix_cols
  function automatic logic [31:0] key_mix(input logic [31:0] w, input logic [7:0] rc);
    return {sbox(w[23:16], 1'b0) ^ rc, sbox(w[15:8], 1'b0), sbox(w[7:0], 1'b0),
            sbox(w[31:24], 1'b0)};
  endfunction : key_mix
  function automatic logic [127:0] key_fwd(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] n0;
    n0 = k[127:96] ^ key_mix(k[31:0], rc);
    return {n0, n0 ^ k[95:64], n0 ^ k[95:64] ^ k[63:32], n0 ^ k[95:64] ^ k[63:32] ^ k[31:0]};
  endfunction : key_fwd
  function automatic logic [127:0] key_bwd(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] p3;
    p3 = k[31:0] ^ k[63:32];
    return {k[127:96] ^ key_mix(p3, rc), k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], p3};
  endfunction : key_bwd

  aece_core_state_t state;
  logic [3:0]       round;
  logic [127:0]     st;
  logic [127:0]     rk;
  logic [7:0]       rcon;
  logic             dir_dec;
  logic             done_q;
  logic             last;
  logic [127:0]     t_enc;
  logic [127:0]     t_dec;

  // one round of each direction from the current state and round key
  always_comb begin
    last = (round == `AECE_ROUNDS);
    t_enc = shift_rows(sub_bytes(st, 1'b0), 1'b0);
    t_dec = sub_bytes(shift_rows(st, 1'b1), 1'b1) ^ key_bwd(rk, rcon);
  end

  // sequencer; rcon runs backwards for decryption, starting from the last round key
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || cif.abort) begin
      state <= AECE_IDLE;
      round <= 4'h0;
      st <= `AECE_RESET_BLOCK;
      rk <= `AECE_RESET_BLOCK;
      rcon <= `AECE_RCON_FIRST;
      dir_dec <= 1'b0;
    end else begin
      unique case (state)
        AECE_IDLE: begin
          if (cif.start) begin
            st <= cif.data_in ^ cif.key_in;
            rk <= cif.key_in;
            rcon <= cif.decrypt ? `AECE_RCON_LAST : `AECE_RCON_FIRST;
            dir_dec <= cif.decrypt;
            round <= 4'h1;
            state <= AECE_RUN;
          end
        end
        AECE_RUN: begin
          st <= dir_dec ? (last ? t_dec : mix_cols(t_dec, 1'b1))
                        : ((last ? t_enc : mix_cols(t_enc, 1'b0)) ^ key_fwd(rk, rcon));
          rk <= dir_dec ? key_bwd(rk, rcon) : key_fwd(rk, rcon);
          rcon <= dir_dec ? (rcon[0] ? ({1'b0, rcon[7:1]} ^ 8'h8d) : {1'b0, rcon[7:1]})
                          : ({rcon[6:0], 1'b0} ^ (rcon[7] ? 8'h1b : 8'h00));
          round <= round + 4'h1;
          state <= last ? AECE_IDLE : AECE_RUN;
        end
      endcase
    end
  end

  // completion pulse one cycle after the last round
  always_ff @(posedge core_clk_i) begin
    done_q <= !sys_rst_i && !cif.abort && (state == AECE_RUN) && last;
  end

  assign cif.busy = (state == AECE_RUN);
  assign cif.done = done_q;
  assign cif.result = st;
  assign cif.key_out = rk;

  // helper count of busy cycles since the last start; a long repetition would unroll badly
  logic [3:0] busy_cnt;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || (cif.start && !cif.busy)) begin
      busy_cnt <= 4'h0;
    end else if (cif.busy) begin
      busy_cnt <= busy_cnt + 4'h1;
    end
  end

  sequence last_round_s;
    cif.busy && !cif.abort && (busy_cnt == 4'h9);
  endsequence
  sequence run_end_s;
    cif.done && !cif.busy && (busy_cnt == 4'ha);
  endsequence
  round_count_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    last_round_s |=> run_end_s) else $error("core did not finish after ten rounds");
endmodule : aece_core

// ### aece_core_if.sv
// carrier between the engine's access logic and its round core
// assumes both ends run on core_clk_i
`timescale 1ns/1ps
interface aece_core_if;
  logic         start;
  logic         decrypt;
  logic         abort;
  logic [127:0] key_in;
  logic [127:0] data_in;
  logic         busy;
  logic         done;
  logic [127:0] result;
  logic [127:0] key_out;
  modport ctl  (output start, decrypt, abort, key_in, data_in,
                input  busy, done, result, key_out);
  modport core (input  start, decrypt, abort, key_in, data_in,
                output busy, done, result, key_out);
endinterface : aece_core_if

// ### aece_engine.sv
// aes-128 ecb/cbc engine behind the transceiver's sram access window
// assumes link-side access signals are held stable while the sampled access clock is high
// Contract
// - Cipher is AES-128 with 128-bit key and 128-bit block.
// - Engine runs on its own, unaffected by radio activity.
// - A separate 128-bit store holds the initial key, never altered.
// - Control and data reached only by sram accesses in 0x82..0x94.
// - Mode select 1 is key mode; page bytes then load the key.
// - Key and data share 0x84..0x93; mode picks the page.
// - Mode select 0 means ECB on the data page.
// - Direction bit in control register picks encrypt or decrypt.
// - Operand comes from data page 0x84..0x93.
// - Request bit written 1 at 0x83 or 0x94 starts an operation.
// - 0x94 mirrors control so a burst can end with start.
// - Mode, data and start accepted within one continuous write burst.
// - Accesses refused in sleep, deepest low power or reset states.
// - Deepest low power or reset clears configuration, data and keys.
// - Any access to 0x83 during an operation aborts it.
// - Key page reads return final round key of the last run.
// - Initial key stays unchanged and is reused by the next run.
// - Fast access lets new operands go in while results come out.
// - Each written byte returns the byte's previous content, one byte behind.
// - Completion flag at 0x82 rises within 24 us of start.
// - Mode 2 chains: input XORed with previous ciphertext before encryption.
`timescale 1ns/1ps
`include "aece_regs.svh"
module aece_engine
  import aece_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  // sram access link from the spi front end
  input  wire logic       sram_sclk_i,
  input  wire logic       sram_wr_i,
  input  wire logic       sram_rd_i,
  input  wire logic [7:0] sram_addr_i,
  input  wire logic [7:0] sram_wdata_i,
  output logic      [7:0] sram_rdata_o,
  // transceiver power state
  input  wire logic       sleep_state_i,
  input  wire logic       deepest_low_power_state_i,
  input  wire logic       trx_reset_state_i
);
  localparam int ASSERT_DONE_MAX = `AECE_DONE_MAX_CYC;

  function automatic logic [7:0] get_byte(input logic [127:0] v, input logic [3:0] idx);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 16; i++) begin
      b = (idx == 4'(i)) ? v[127-8*i -: 8] : b;
    end
    return b;
  endfunction : get_byte

  function automatic logic [127:0] put_byte(input logic [127:0] v, input logic [3:0] idx,
                                            input logic [7:0] b);
    logic [127:0] o;
    o = v;
    for (int i = 0; i < 16; i++) begin
      o[127-8*i -: 8] = (idx == 4'(i)) ? b : v[127-8*i -: 8];
    end
    return o;
  endfunction : put_byte

  // unknown mode codes fall back to ecb
  // ecb by default
  function automatic aece_mode_t decode_mode(input logic [2:0] m);
    return (m == AECE_MODE_KEY) ? AECE_MODE_KEY :
           (m == AECE_MODE_CBC) ? AECE_MODE_CBC : AECE_MODE_ECB;
  endfunction : decode_mode

  logic         sclk_q1;
  logic         sclk_q2;
  logic         sclk_q3;
  logic         sclk_lvl;
  logic         sclk_rise;
  logic         acc_vld;
  logic         acc_wr;
  logic         acc_rd;
  logic [7:0]   acc_addr;
  logic [7:0]   acc_wdata;
  logic [7:0]   acc_offs;
  logic [3:0]   acc_idx;
  logic         hit_status;
  logic         hit_ctrl;
  logic         hit_page;
  logic         refuse;
  logic         wipe;
  logic         take;
  logic         ctrl_wr;
  aece_mode_t   ctrl_mode;
  aece_mode_t   new_mode;
  logic         ctrl_dir;
  logic [127:0] init_key;
  logic [127:0] key_page;
  logic [127:0] data_page;
  logic [127:0] prev_ct;
  logic         stat_done;
  logic         stat_err;
  logic         start_q;
  logic         abort_q;
  logic [7:0]   next_rdata;

  aece_core_if cif ();

  // access clock passes three flops; an edge counts once the last two agree
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sclk_q1 <= 1'b0;
      sclk_q2 <= 1'b0;
      sclk_q3 <= 1'b0;
      sclk_lvl <= 1'b0;
    end else begin
      sclk_q1 <= sram_sclk_i;
      sclk_q2 <= sclk_q1;
      sclk_q3 <= sclk_q2;
      sclk_lvl <= (sclk_q2 == sclk_q3) ? sclk_q3 : sclk_lvl;
    end
  end
  assign sclk_rise = (sclk_q2 == sclk_q3) && sclk_q3 && !sclk_lvl;

  // access is captured once per rising access clock, then handled next cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      acc_vld <= 1'b0;
      acc_wr <= 1'b0;
      acc_rd <= 1'b0;
      acc_addr <= `AECE_RESET_BYTE;
      acc_wdata <= `AECE_RESET_BYTE;
    end else begin
      acc_vld <= sclk_rise && (sram_wr_i || sram_rd_i);
      acc_wr <= sram_wr_i;
      acc_rd <= sram_rd_i && !sram_wr_i;
      acc_addr <= sclk_rise ? sram_addr_i : acc_addr;
      acc_wdata <= sclk_rise ? sram_wdata_i : acc_wdata;
    end
  end

  always_comb begin
    acc_offs = acc_addr - `AECE_ADDR_PAGE_LO;
    acc_idx = acc_offs[3:0];
    hit_status = (acc_addr == `AECE_ADDR_STATUS);
    hit_ctrl = (acc_addr == `AECE_ADDR_CTRL) || (acc_addr == `AECE_ADDR_ALIAS);
    hit_page = (acc_addr >= `AECE_ADDR_PAGE_LO) && (acc_addr <= `AECE_ADDR_PAGE_HI);
  end

  assign refuse = sleep_state_i || deepest_low_power_state_i || trx_reset_state_i;
  assign wipe = deepest_low_power_state_i || trx_reset_state_i;
  assign take = acc_vld && !refuse;
  assign ctrl_wr = take && acc_wr && hit_ctrl;
  assign new_mode = decode_mode(acc_wdata[`AECE_CTRL_MODE_HI:`AECE_CTRL_MODE_LO]);

  // mode and direction; a burst from 0x83 updates them before its data bytes land
  // single burst config
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wipe) begin
      ctrl_mode <= AECE_MODE_ECB;
      ctrl_dir <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_mode <= new_mode;
      ctrl_dir <= acc_wdata[`AECE_CTRL_DIR_BIT];
    end
  end

  // start and abort pulses; an access to control while busy aborts instead of starting
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wipe) begin
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      start_q <= ctrl_wr && acc_wdata[`AECE_CTRL_REQ_BIT] && !cif.busy
                 && (new_mode != AECE_MODE_KEY);
      abort_q <= take && hit_ctrl && cif.busy;
    end
  end

  // key pages: the initial store feeds each run, the readable page shows the round key
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wipe) begin
      init_key <= `AECE_RESET_BLOCK;
      key_page <= `AECE_RESET_BLOCK;
    end else if (take && acc_wr && hit_page && (ctrl_mode == AECE_MODE_KEY)) begin
      init_key <= put_byte(init_key, acc_idx, acc_wdata);
      key_page <= put_byte(cif.done ? cif.key_out : key_page, acc_idx, acc_wdata);
    end else if (cif.done) begin
      key_page <= cif.key_out;
    end
  end

  // data page; a host byte written alongside completion wins over the result
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wipe) begin
      data_page <= `AECE_RESET_BLOCK;
    end else if (take && acc_wr && hit_page && (ctrl_mode != AECE_MODE_KEY)) begin
      data_page <= put_byte(cif.done ? cif.result : data_page, acc_idx, acc_wdata);
    end else if (cif.done) begin
      data_page <= cif.result;
    end
  end

  // previous ciphertext for chaining, kept apart since the host overwrites the page
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wipe) begin
      prev_ct <= `AECE_RESET_BLOCK;
    end else if (cif.done && !ctrl_dir) begin
      prev_ct <= cif.result;
    end
  end

  // status flags; a new start clears them, an abort raises the error
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wipe) begin
      stat_done <= 1'b0;
      stat_err <= 1'b0;
    end else begin
      stat_done <= cif.done || (stat_done && !start_q);
      stat_err <= abort_q || (stat_err && !start_q);
    end
  end

  // read view; request reads back as zero
  always_comb begin
    next_rdata = `AECE_RESET_BYTE;
    if (hit_status) begin
      next_rdata[`AECE_STAT_ERR_BIT] = stat_err;
      next_rdata[`AECE_STAT_DONE_BIT] = stat_done;
    end else if (hit_ctrl) begin
      next_rdata[`AECE_CTRL_MODE_HI:`AECE_CTRL_MODE_LO] = ctrl_mode;
      next_rdata[`AECE_CTRL_DIR_BIT] = ctrl_dir;
    end else if (hit_page) begin
      next_rdata = get_byte((ctrl_mode == AECE_MODE_KEY) ? key_page : data_page, acc_idx);
    end
  end

  // write returns old byte; the spi shifter adds the one-byte lag
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wipe) begin
      sram_rdata_o <= `AECE_RESET_BYTE;
    end else if (take) begin
      sram_rdata_o <= next_rdata;
    end
  end

  // core hookup; it runs on the core clock whatever the radio does
  assign cif.start = start_q;
  assign cif.decrypt = ctrl_dir;
  assign cif.abort = abort_q || wipe;
  assign cif.key_in = init_key;
  assign cif.data_in = ((ctrl_mode == AECE_MODE_CBC) && !ctrl_dir) ? (data_page ^ prev_ct)
                                                                     : data_page;

  aece_core u_core (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .cif        (cif)
  );

  // helper: cycles since the last start still waiting for a flag; the bound lies
  // beyond what a delay range may span, so a counter carries it
  logic        done_pend;
  logic [11:0] done_wait;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wipe) begin
      done_pend <= 1'b0;
      done_wait <= 12'h000;
    end else if (start_q) begin
      done_pend <= 1'b1;
      done_wait <= 12'h000;
    end else if (done_pend) begin
      done_pend <= !(stat_done || stat_err);
      done_wait <= done_wait + 12'h001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence ctrl_start_s;
    ctrl_wr && acc_wdata[`AECE_CTRL_REQ_BIT] && !cif.busy && (new_mode != AECE_MODE_KEY);
  endsequence
  sequence run_starts_s;
    start_q ##1 cif.busy;
  endsequence

  start_request_a: assert property (
    ctrl_start_s |=> run_starts_s) else $error("request did not start the core");
  done_bound_a: assert property (
    done_pend |-> (done_wait <= 12'(ASSERT_DONE_MAX)))
    else $error("completion flag late");
  alias_ctrl_a: assert property (
    ctrl_wr && (acc_addr == `AECE_ADDR_ALIAS) |=> ctrl_mode == $past(new_mode))
    else $error("alias write did not reach control");
  abort_access_a: assert property (
    take && hit_ctrl && cif.busy |=> abort_q ##1 (!cif.busy && stat_err))
    else $error("control access did not abort");
  key_store_a: assert property (
    cif.busy && !wipe |=> $stable(init_key)) else $error("initial key changed while busy");
  refuse_access_a: assert property (
    acc_vld && refuse && !wipe
    |=> $stable(ctrl_mode) && $stable(init_key) && $stable(sram_rdata_o))
    else $error("refused access had an effect");
  wipe_clear_a: assert property (
    wipe |=> (init_key == 128'h0) && (data_page == 128'h0) && !stat_done && !cif.busy)
    else $error("low power state did not clear engine");
  result_store_a: assert property (
    cif.done && !(take && acc_wr && hit_page) |=> data_page == $past(cif.result))
    else $error("result not placed on data page");
  round_key_a: assert property (
    cif.done && !(take && acc_wr && hit_page) |=> key_page == $past(cif.key_out))
    else $error("round key not shown on key page");
  chain_input_a: assert property (
    start_q && (ctrl_mode == AECE_MODE_CBC) && !ctrl_dir
    |=> cif.busy && ($past(cif.data_in) == ($past(data_page) ^ $past(prev_ct))))
    else $error("chaining input wrong");
  fast_old_byte_a: assert property (
    take && acc_wr && hit_page && (ctrl_mode != AECE_MODE_KEY)
    |=> sram_rdata_o == get_byte($past(data_page), $past(acc_idx)))
    else $error("write did not return previous byte");
endmodule : aece_engine

// ### aece_host_model.sv
// host model: byte accesses on the sram access link of the cipher engine
// assumes the engine samples sram_sclk_i with its own core clock
`timescale 1ns/1ps
module aece_host_model (
  // access link toward the engine
  output logic       sram_sclk_o,
  output logic       sram_wr_o,
  output logic       sram_rd_o,
  output logic [7:0] sram_addr_o,
  output logic [7:0] sram_wdata_o,
  // byte returned by the engine
  input  wire logic [7:0] sram_rdata_i
);
  // link clock stands low outside accesses
  initial begin
    sram_sclk_o  = 1'b0;
    sram_wr_o    = 1'b0;
    sram_rd_o    = 1'b0;
    sram_addr_o  = 8'h00;
    sram_wdata_o = 8'h00;
  end

  // one byte per 125 ns link period; lines held for the whole high phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    sram_wr_o    = w;
    sram_rd_o    = !w;
    sram_addr_o  = a;
    sram_wdata_o = d;
    #10 sram_sclk_o = 1'b1;
    #60 r = sram_rdata_i;
    #2.5 sram_sclk_o = 1'b0;
    // released address and data lines show the inverse, so a stale copy is never trusted
    sram_wr_o    = 1'b0;
    sram_rd_o    = 1'b0;
    sram_addr_o  = ~a;
    sram_wdata_o = ~d;
    #52.5;
  endtask : xfer
endmodule : aece_host_model

// ### aece_pkg.sv
// types shared by the cipher engine and its round core
// assumes aece_regs.svh is on the include path
`include "aece_regs.svh"
package aece_pkg;
  // cipher mode select values as stored in the control register
  typedef enum logic [2:0] {
    AECE_MODE_ECB = 3'h0,
    AECE_MODE_KEY = 3'h1,
    AECE_MODE_CBC = 3'h2
  } aece_mode_t;
  // round core sequencer, one-hot
  typedef enum logic [1:0] {
    AECE_IDLE = 2'b01,
    AECE_RUN  = 2'b10
  } aece_core_state_t;
endpackage : aece_pkg

// ### aece_regs.svh
// address map, field positions, reset values and timing counts of the cipher engine
// assumes the includer compiles it once per unit; guard prevents double definitions
`ifndef AECE_REGS_SVH
`define AECE_REGS_SVH
`define AECE_ADDR_STATUS   8'h82
`define AECE_ADDR_CTRL     8'h83
`define AECE_ADDR_PAGE_LO  8'h84
`define AECE_ADDR_PAGE_HI  8'h93
`define AECE_ADDR_ALIAS    8'h94
`define AECE_CTRL_REQ_BIT  7
`define AECE_CTRL_MODE_HI  6
`define AECE_CTRL_MODE_LO  4
`define AECE_CTRL_DIR_BIT  3
`define AECE_STAT_ERR_BIT  7
`define AECE_STAT_DONE_BIT 0
`define AECE_RESET_BYTE    8'h00
`define AECE_RESET_BLOCK   128'h0
`define AECE_ROUNDS        4'ha
`define AECE_RCON_FIRST    8'h01
`define AECE_RCON_LAST     8'h36
`define AECE_CLK_PERIOD_NS 10
`define AECE_T_DONE_MAX_US 24
`define AECE_DONE_MAX_CYC  ((`AECE_T_DONE_MAX_US * 1000) / `AECE_CLK_PERIOD_NS)
`endif

// ### tb.sv
// self-checking bench for the cipher engine behind its sram access window
// assumes aece_regs.svh on the include path and the host model beside it
`timescale 1ns/1ps
`include "aece_regs.svh"
module tb;
  localparam logic [127:0] KEY = 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
  localparam logic [127:0] PT  = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  localparam logic [127:0] CT  = 128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a;
  localparam logic [127:0] K10 = 128'h1311_1d7f_e394_4a17_f307_a78b_4d2b_30c5;
  logic       core_clk_i;
  logic       sys_rst_i;
  logic       sclk, wr, rd, slp, deep, trst;
  logic [7:0] addr, wdata, rdata, rb;
  int         bad_count, total_checks;

  aece_engine u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sram_sclk_i(sclk),
    .sram_wr_i(wr), .sram_rd_i(rd), .sram_addr_i(addr), .sram_wdata_i(wdata),
    .sram_rdata_o(rdata), .sleep_state_i(slp), .deepest_low_power_state_i(deep),
    .trx_reset_state_i(trst));
  aece_host_model u_host (.sram_sclk_o(sclk), .sram_wr_o(wr), .sram_rd_o(rd),
    .sram_addr_o(addr), .sram_wdata_o(wdata), .sram_rdata_i(rdata));

  // 100 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : check

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(w, a, d, rb);
  endtask : acc

  // control, sixteen bytes, then the start on the alias when go sets the request bit, one burst
  task automatic load(input logic [7:0] ctrl, input logic [127:0] blk, input logic [7:0] go);
    acc(1'b1, `AECE_ADDR_CTRL, ctrl);
    for (int i = 0; i < 16; i++) acc(1'b1, `AECE_ADDR_PAGE_LO + 8'(i), blk[127-8*i -: 8]);
    if (go[7]) acc(1'b1, `AECE_ADDR_ALIAS, go);
  endtask : load

  task automatic rd_blk(input logic [127:0] exp);
    logic [127:0] got;
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, `AECE_ADDR_PAGE_LO + 8'(i), 8'h00);
      got[127-8*i -: 8] = rb;
    end
    check(got, exp);
  endtask : rd_blk

  // polls status; bound of 200 polls is 25 us, just past 24 us worth of polls
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      acc(1'b0, `AECE_ADDR_STATUS, 8'h00);
      n++;
    end while (rb !== 8'h01 && n < 200);
    check(rb, 8'h01);
  endtask : wait_done

  task automatic t_reset;
    acc(1'b0, `AECE_ADDR_STATUS, 8'h00);
    check(rb, 8'h00);
    acc(1'b0, `AECE_ADDR_CTRL, 8'h00);
    check(rb, 8'h00);
    acc(1'b0, 8'h95, 8'h00);
    check(rb, 8'h00);
    // an unknown mode code stores as ecb; the alias reads back the control byte
    acc(1'b1, `AECE_ADDR_CTRL, 8'h78);
    acc(1'b0, `AECE_ADDR_ALIAS, 8'h00);
    check(rb, 8'h08);
  endtask : t_reset

  task automatic t_encrypt;
    load(8'h10, KEY, 8'h00);
    for (int k = 0; k < 2; k++) begin
      load(8'h00, PT, 8'h80);
      wait_done();
      rd_blk(CT);
    end
    // chaining: input xored with the last ciphertext gives the plain block again
    load(8'h20, PT ^ CT, 8'ha0);
    wait_done();
    rd_blk(CT);
    acc(1'b1, `AECE_ADDR_CTRL, 8'h10);
    rd_blk(K10);
  endtask : t_encrypt

  task automatic t_decrypt;
    load(8'h10, K10, 8'h00);
    load(8'h08, CT, 8'h88);
    wait_done();
    rd_blk(PT);
    acc(1'b1, `AECE_ADDR_PAGE_LO + 8'h01, 8'haa);
    check(rb, 8'h11);
    acc(1'b0, `AECE_ADDR_PAGE_LO + 8'h01, 8'h00);
    check(rb, 8'haa);
  endtask : t_decrypt

  // refused while asleep; cleared by deepest state and by transceiver reset
  task automatic t_power;
    @(negedge core_clk_i) slp = 1'b1;
    acc(1'b1, `AECE_ADDR_PAGE_LO + 8'h01, 8'h55);
    @(negedge core_clk_i) slp = 1'b0;
    acc(1'b0, `AECE_ADDR_PAGE_LO + 8'h01, 8'h00);
    check(rb, 8'haa);
    for (int s = 0; s < 2; s++) begin
      acc(1'b1, `AECE_ADDR_PAGE_LO + 8'h01, 8'h55);
      @(negedge core_clk_i) {deep, trst} = (s == 0) ? 2'b10 : 2'b01;
      repeat (4) @(negedge core_clk_i);
      {deep, trst} = 2'b00;
      acc(1'b0, `AECE_ADDR_PAGE_LO + 8'h01, 8'h00);
      check(rb, 8'h00);
    end
  endtask : t_power

  task automatic conclude;
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // main sequence after 20 cycles of reset
  initial begin
    bad_count    = 0;
    total_checks = 0;
    sys_rst_i    = 1'b1;
    {slp, deep, trst} = 3'b000;
    repeat (20) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    t_reset();
    t_encrypt();
    t_decrypt();
    t_power();
    conclude();
  end

  // watchdog: roughly ten times the expected run
  initial begin
    #300000;
    bad_count++;
    conclude();
  end
endmodule : tb
